// File: include/ssc_cfg.svh
// constants for the serial port core: offsets, fields, resets
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_ADR_CTRL 8'h00
`define SSC_ADR_STAT 8'h04
`define SSC_ADR_DATA 8'h08
`define SSC_ADR_DIV 8'h0c
`define SSC_CTRL_EN 0
`define SSC_CTRL_CKPOL 1
`define SSC_CTRL_CLOCK_PHASE_SEL 2
`define SSC_CTRL_W16 3
`define SSC_CTRL_LSB 4
`define SSC_CTRL_CTRLR 5
`define SSC_CTRL_SWEN 6
`define SSC_CTRL_SWLVL 7
`define SSC_CTRL_SELDRV 8
`define SSC_CTRL_RO 9
`define SSC_CTRL_BIDIR_EN 10
`define SSC_CTRL_BDOE 11
`define SSC_CTRL_FP 12
`define SSC_CTRL_RST 13'h0080
`define SSC_DIV_RST 8'h04
`define SSC_STAT_RXF 0
`define SSC_STAT_TXE 1
`define SSC_STAT_FAULT 2
`define SSC_STAT_BUSY 3
`define SSC_STAT_ROLE 4
`endif

// File: include/ssc_pkg.sv
// types shared by the serial port core
package ssc_pkg;
    typedef enum logic [1:0] {SSC_IDLE, SSC_RUN, SSC_DONE} ssc_state_e;
    typedef logic [15:0] ssc_word_t;
endpackage

// File: include/ssc_buf_if.sv
// interface between the core and its word buffer
`timescale 1ns/1ns
interface ssc_buf_if;
    logic we;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport core (output we, output wdata, input rdata);
    modport mem (input we, input wdata, output rdata);
endinterface

// File: core/ssc_word_buf.sv
// one-word buffer with registered read data
`timescale 1ns/1ns
module ssc_word_buf
(
    input wire logic ref_clk,
    input wire logic rstn,
    ssc_buf_if.mem bus
);
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            bus.rdata <= 16'h0000;
        else if (bus.we)
            bus.rdata <= bus.wdata;
    end
endmodule

// File: core/ssc_core.sv
// serial peripheral port core with wishbone registers
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "ssc_cfg.svh"
//  Function
// - polarity sets idle clock, phase picks edge
// - frame-pulse format ignores polarity and phase
// - frame is 16 or 8 bits
// - lsb first when selector set
// - frame-pulse format always msb first
// - target select from pin or soft level
// - soft select ignores pin, 0 selected
// - controller seeing select low becomes target, fault, unless it drives select itself (select drive set, soft select off)
// - controller drives select pin low when enabled with select drive set and soft select off
// - clock output as controller, input as target
// - two-line: controller mosi out, target miso out
// - bidirectional: controller uses mosi, target miso
// - controller full duplex: mosi out, miso in
// - controller transmit-only leaves miso unused
// - controller receive-only: miso in, mosi unused
// - controller bidir transmit drives shared line
// - controller bidir receive listens on mosi
// - separate 16-bit transmit and receive buffers
// - frame-pulse format samples on falling edge
// - controller starts on write; target on clock
// - last sample moves shift into rx buffer
// - receive-only controller clocks until disabled
module ssc_core
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic nss_i,
    output logic nss_o,
    output logic nss_oe
);
    logic [12:0] ctrl;
    logic [7:0] half_div;
    logic rx_full;
    logic tx_full;
    logic fault;
    logic [15:0] shifter;
    logic [4:0] bit_cnt;
    logic [7:0] div_cnt;
    logic sck_int;
    logic edge_phase;
    ssc_pkg::ssc_state_e state;
    logic [2:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] miso_s;
    logic [1:0] nss_s;
    logic load_tx;
    logic dout;
    ssc_buf_if txb();
    ssc_buf_if rxb();

    ssc_word_buf u_txbuf (.ref_clk(ref_clk), .rstn(rstn), .bus(txb));
    ssc_word_buf u_rxbuf (.ref_clk(ref_clk), .rstn(rstn), .bus(rxb));

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
        reg_hit = (a == r);
    endfunction

    wire en = ctrl[`SSC_CTRL_EN];
    wire fp = ctrl[`SSC_CTRL_FP];
    wire ctl_role = ctrl[`SSC_CTRL_CTRLR];
    wire bidir_en = ctrl[`SSC_CTRL_BIDIR_EN];
    wire bdoe = ctrl[`SSC_CTRL_BDOE];
    wire ro = ctrl[`SSC_CTRL_RO];
    wire w16 = ctrl[`SSC_CTRL_W16];
    // frame-pulse format forces idle low, second-edge-is-falling sampling
    wire cpol = fp ? 1'b0 : ctrl[`SSC_CTRL_CKPOL];
    wire cpha = fp ? 1'b1 : ctrl[`SSC_CTRL_CLOCK_PHASE_SEL];
    wire lsb = fp ? 1'b0 : ctrl[`SSC_CTRL_LSB];
    wire [4:0] frame_len = w16 ? 5'h10 : 5'h08;
    wire sel_lvl = ctrl[`SSC_CTRL_SWEN] ? ctrl[`SSC_CTRL_SWLVL]
        : nss_s[1];
    wire selected = ~sel_lvl;
    wire sel_in_use = ctrl[`SSC_CTRL_SWEN] | ~ctrl[`SSC_CTRL_SELDRV];
    wire tx_dir = ~ro & ~(bidir_en & ~bdoe);
    wire rx_only = ro | (bidir_en & ~bdoe);

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire adr_ok = reg_hit(wb_adr_i, `SSC_ADR_CTRL)
        | reg_hit(wb_adr_i, `SSC_ADR_STAT)
        | reg_hit(wb_adr_i, `SSC_ADR_DATA)
        | reg_hit(wb_adr_i, `SSC_ADR_DIV);
    wire wr_data = wb_req & wb_we_i & reg_hit(wb_adr_i, `SSC_ADR_DATA)
        & wb_sel_i[0];
    wire rd_data = wb_req & ~wb_we_i & reg_hit(wb_adr_i, `SSC_ADR_DATA);

    // synchronisers: first stage only feeds the second
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sck_s <= 3'h0;
            mosi_s <= 2'h0;
            miso_s <= 2'h0;
            nss_s <= 2'h3;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck_i};
            mosi_s <= {mosi_s[0], mosi_i};
            miso_s <= {miso_s[0], miso_i};
            nss_s <= {nss_s[0], nss_i};
        end
    end

    // wishbone answer, one cycle after the request
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req & adr_ok;
            wb_err_o <= wb_req & ~adr_ok;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            wb_dat_o <= 32'h00000000;
        else if (wb_req & ~wb_we_i)
        begin
            wb_dat_o <= 32'h00000000;
            if (reg_hit(wb_adr_i, `SSC_ADR_CTRL))
                wb_dat_o <= {19'h00000, ctrl};
            else if (reg_hit(wb_adr_i, `SSC_ADR_STAT))
                wb_dat_o <= {27'h0000000, ctl_role, state != ssc_pkg::SSC_IDLE,
                    fault, ~tx_full, rx_full};
            else if (reg_hit(wb_adr_i, `SSC_ADR_DATA))
                wb_dat_o <= {16'h0000, rxb.rdata};
            else if (reg_hit(wb_adr_i, `SSC_ADR_DIV))
                wb_dat_o <= {24'h000000, half_div};
        end
    end

    // control register; role bit is also dropped by a select fault
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            ctrl <= `SSC_CTRL_RST;
        else if (en & ctl_role & sel_in_use & selected)
            ctrl[`SSC_CTRL_CTRLR] <= 1'b0;
        else if (wb_req & wb_we_i & reg_hit(wb_adr_i, `SSC_ADR_CTRL))
        begin
            if (wb_sel_i[0])
                ctrl[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl[12:8] <= wb_dat_i[12:8];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            half_div <= `SSC_DIV_RST;
        else if (wb_req & wb_we_i & reg_hit(wb_adr_i, `SSC_ADR_DIV)
            & wb_sel_i[0])
            half_div <= (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
    end

    // fault: set wins over a clear by writing the status word
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            fault <= 1'b0;
        else if (en & ctl_role & sel_in_use & selected)
            fault <= 1'b1;
        else if (wb_req & wb_we_i & reg_hit(wb_adr_i, `SSC_ADR_STAT)
            & wb_sel_i[0] & wb_dat_i[`SSC_STAT_FAULT])
            fault <= 1'b0;
    end

    // transmit buffer holds one word; a load frees it
    assign txb.we = wr_data;
    assign txb.wdata = wb_dat_i[15:0];
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            tx_full <= 1'b0;
        else if (wr_data)
            tx_full <= 1'b1;
        else if (load_tx)
            tx_full <= 1'b0;
    end

    wire frame_end = (state == ssc_pkg::SSC_DONE);
    assign rxb.we = frame_end;
    assign rxb.wdata = w16 ? shifter : {8'h00, shifter[7:0]};
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            rx_full <= 1'b0;
        else if (rxb.we)
            rx_full <= 1'b1;
        else if (rd_data)
            rx_full <= 1'b0;
    end

    // edge detection of the target clock, taken after the synchroniser
    wire sck_rise = sck_s[1] & ~sck_s[2];
    wire sck_fall = ~sck_s[1] & sck_s[2];
    wire ext_edge = sck_rise | sck_fall;
    wire ext_lead = (sck_s[1] ^ cpol); // level after a leading edge
    wire div_tick = (div_cnt == half_div - 8'h01);

    // start conditions: controller on data, or continuous receive; target on a clock edge while selected
    wire ctl_go = en & ctl_role & (tx_full | rx_only);
    wire tgt_go = en & ~ctl_role & selected & ext_edge;
    assign load_tx = (state == ssc_pkg::SSC_IDLE) & (ctl_go | tgt_go);

    // edge events: a leading edge or a trailing edge of the serial clock
    wire ctl_edge = ctl_role & (state == ssc_pkg::SSC_RUN) & div_tick;
    wire lead_edge = ctl_role ? (ctl_edge & ~edge_phase)
        : (ext_edge & ext_lead);
    wire trail_edge = ctl_role ? (ctl_edge & edge_phase)
        : (ext_edge & ~ext_lead);
    wire sample_edge = cpha ? trail_edge : lead_edge;
    wire shift_edge = cpha ? lead_edge : trail_edge;
    wire rx_bit = ctl_role ? (bidir_en ? mosi_s[1] : miso_s[1])
        : (bidir_en ? miso_s[1] : mosi_s[1]);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            div_cnt <= 8'h00;
        else if (state != ssc_pkg::SSC_RUN || div_tick)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // frame sequencer
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state <= ssc_pkg::SSC_IDLE;
            bit_cnt <= 5'h00;
            edge_phase <= 1'b0;
            sck_int <= 1'b0;
            shifter <= 16'h0000;
            dout <= 1'b0;
        end
        else
        begin
            case (state)
                ssc_pkg::SSC_IDLE:
                begin
                    sck_int <= 1'b0;
                    edge_phase <= 1'b0;
                    bit_cnt <= 5'h00;
                    if (load_tx)
                    begin
                        // buffer word loaded in the same cycle; previous
                        // word if none was written (target underrun)
                        shifter <= txb.rdata;
                        dout <= lsb ? txb.rdata[0]
                            : (w16 ? txb.rdata[15] : txb.rdata[7]);
                        state <= ssc_pkg::SSC_RUN;
                        if (tgt_go & ext_lead & ~cpha)
                        begin
                            // first edge already seen: sample now
                            bit_cnt <= 5'h01;
                            shifter <= lsb
                                ? (w16 ? {rx_bit, txb.rdata[15:1]}
                                    : {8'h00, rx_bit, txb.rdata[7:1]})
                                : {txb.rdata[14:0], rx_bit};
                        end
                    end
                end
                ssc_pkg::SSC_RUN:
                begin
                    if (!en || (!ctl_role && !selected))
                        state <= ssc_pkg::SSC_IDLE;
                    else
                    begin
                        if (ctl_edge)
                        begin
                            sck_int <= ~sck_int;
                            edge_phase <= ~edge_phase;
                        end
                        if (sample_edge)
                        begin
                            bit_cnt <= bit_cnt + 5'h01;
                            if (w16 || lsb == 1'b0)
                                shifter <= lsb
                                    ? {rx_bit, shifter[15:1]}
                                    : {shifter[14:0], rx_bit};
                            else
                                shifter <= {8'h00, rx_bit, shifter[7:1]};
                            if (bit_cnt == frame_len - 5'h01)
                                state <= ssc_pkg::SSC_DONE;
                        end
                        if (shift_edge && bit_cnt != 5'h00)
                            dout <= lsb ? shifter[0]
                                : (w16 ? shifter[15] : shifter[7]);
                    end
                end
                ssc_pkg::SSC_DONE:
                begin
                    // controller returns clock to idle before next frame
                    sck_int <= 1'b0;
                    state <= ssc_pkg::SSC_IDLE;
                end
                default:
                    state <= ssc_pkg::SSC_IDLE;
            endcase
        end
    end

    // pin drive
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            nss_o <= 1'b1;
            nss_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
        end
        else
        begin
            sck_o <= cpol ^ sck_int;
            sck_oe <= en & ctl_role;
            nss_oe <= en & ctl_role & ~ctrl[`SSC_CTRL_SWEN]
                & ctrl[`SSC_CTRL_SELDRV];
            nss_o <= 1'b0;
            mosi_o <= dout;
            miso_o <= dout;
            // controller: mosi out in full duplex, tx-only, bidir tx
            mosi_oe <= en & ctl_role & tx_dir;
            // target: miso out when transmitting and selected
            miso_oe <= en & ~ctl_role & selected & tx_dir;
        end
    end
endmodule

// File: testbench/ssc_core_properties.sv
// concurrent checks on the serial port core's top ports
`timescale 1ns/1ns
module ssc_core_properties
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic nss_o,
    input wire logic nss_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c};
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");
    a_bus_answer: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");
    a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_no_stray_ack: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without a request");
    a_one_data_driver: assert property (!(mosi_oe && miso_oe))
        else $error("both data lines driven");
    a_target_clk_in: assert property (miso_oe |-> !sck_oe)
        else $error("target drives the clock");
    // level and enable are launched by the same edge
    a_sel_drive_low: assert property (nss_oe |-> !nss_o)
        else $error("driven select not low");
endmodule
bind ssc_core ssc_core_properties ssc_core_properties_i
(
    .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .nss_o(nss_o), .nss_oe(nss_oe)
);

// File: testbench/ssc_peer_model.sv
// behavioural spi target standing at the far side of the core
`timescale 1ns/1ns
module ssc_peer_model
(
    input wire logic clk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic nss,
    input wire logic cpha,
    input wire logic [15:0] tx,
    output logic miso,
    output logic [15:0] rx
);
    logic [16:0] sh = 17'h00000;
    logic tgl = 1'b0;
    initial rx = 16'h0000;
    always @(posedge clk) tgl <= ~tgl;
    // released line toggles so a stale bit cannot pass
    assign miso = nss ? tgl : sh[16];
    // word must be loaded before the first clock edge
    always @(negedge nss) sh <= cpha ? {1'b0, tx} : {tx, 1'b0};
    always @(posedge sck)
    begin
        if (!nss && cpha)
            sh <= sh << 1;
        if (!nss && !cpha)
            rx <= {rx[14:0], mosi};
    end
    always @(negedge sck)
    begin
        if (!nss && !cpha)
            sh <= sh << 1;
        if (!nss && cpha)
            rx <= {rx[14:0], mosi};
    end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the serial port core as controller
`timescale 1ns/1ns
`include "ssc_cfg.svh"
`define CHK(a, x) begin n_checks++; if ((a) !== (x)) begin miscompares++; \
    $display("ERROR at %0t got %h exp %h", $time, a, x); end end
module tb_top;
    typedef struct {logic [15:0] e; logic [15:0] m;} ssc_note_s;
    logic ref_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic chk_rd = 1'b0, flip = 1'b0, nss_pull = 1'b1, cpha_m = 1'b0, e;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000, rd, rdat, seed = 32'h0000003d;
    logic ack, err, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic nss_o, nss_oe, peer_miso;
    logic [15:0] peer_tx = 16'h0000, peer_rx;
    int miscompares = 0, n_checks = 0;
    ssc_note_s notes[$];
    ssc_note_s note;
    // bits: receive-only, frame-pulse, width16, lsb first, phase
    logic [4:0] cfg [6] = '{5'h00, 5'h02, 5'h05, 5'h06, 5'h0a, 5'h11};
    logic [31:0] fv [3] = '{32'h00000021, 32'h00000061, 32'h000000e1};
    logic fpin [3] = '{1'b0, 1'b1, 1'b0};
    logic [15:0] fe [3] = '{16'h0004, 16'h0004, 16'h0010};
    wire sck_pin = sck_oe ? sck_o : 1'b0; // pull-down on the clock
    wire nss_pin = nss_oe ? nss_o : nss_pull;
    wire mosi_pin = mosi_oe ? mosi_o : flip;
    wire miso_pin = miso_oe ? miso_o : peer_miso;
    ssc_core ssc_core_i (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_pin),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_pin),
        .miso_o(miso_o), .miso_oe(miso_oe), .nss_i(nss_pin), .nss_o(nss_o),
        .nss_oe(nss_oe));
    ssc_peer_model ssc_peer_model_i (.clk(ref_clk), .sck(sck_pin),
        .mosi(mosi_pin), .nss(nss_pin), .cpha(cpha_m), .tx(peer_tx),
        .miso(peer_miso), .rx(peer_rx));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // value of w wire bits as seen first-bit-high
    function automatic logic [15:0] order(input logic [15:0] d, input int w,
        input logic l);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < w; i++)
            r[i] = l ? d[w-1-i] : d[i];
        return r;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic c, input logic [15:0] ev, input logic [15:0] mv);
        int n;
        n = 0;
        if (c)
            notes.push_back('{ev, mv});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        chk_rd <= c;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        rd = rdat;
        e = err;
        cyc <= 1'b0; stb <= 1'b0; chk_rd <= 1'b0;
        @(posedge ref_clk);
        if (n >= 50)
        begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 1'b0, 16'h0000, 16'h0000);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [15:0] ev,
        input logic [15:0] mv);
        wb(1'b0, a, 32'h00000000, 1'b1, ev, mv);
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) flip <= ~flip;
    always @(posedge ref_clk)
        if (ack === 1'b1 && chk_rd === 1'b1)
        begin
            note = notes.pop_front();
            `CHK(rdat[15:0] & note.m, note.e)
        end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rdx(`SSC_ADR_CTRL, 16'h0080, 16'h1fff);
        rdx(`SSC_ADR_DIV, 16'h0004, 16'h00ff);
        wb(1'b0, 8'h10, 32'h00000000, 1'b0, 16'h0000, 16'h0000);
        `CHK(e, 1'b1)
        wr(`SSC_ADR_DIV, 32'h00000008); // 160 ns serial clock
        for (int k = 0; k < 6; k++)
        begin
            logic [4:0] c;
            int w, n;
            logic l;
            logic [15:0] d, m, msk;
            c = cfg[k];
            w = c[2] ? 16 : 8;
            l = c[1] & ~c[3];
            msk = c[2] ? 16'hffff : 16'h00ff;
            seed = xs(seed);
            d = seed[15:0] & msk;
            peer_tx <= seed[31:16];
            m = c[2] ? seed[31:16] : {8'h00, seed[31:24]};
            cpha_m <= c[0] | c[3];
            wr(`SSC_ADR_CTRL, 32'h00000000);
            wr(`SSC_ADR_CTRL, {19'h0, c[3], 2'h0, c[4], 4'hd, c[1], c[2],
                c[0], 2'h1});
            wr(`SSC_ADR_DATA, {16'h0000, d});
            n = 0;
            do
            begin
                wb(1'b0, `SSC_ADR_STAT, 32'h0, 1'b0, 16'h0, 16'h0);
                n++;
            end while (rd[`SSC_STAT_RXF] !== 1'b1 && n < 200);
            if (n >= 200)
            begin
                miscompares++;
                conclude();
            end
            rdx(`SSC_ADR_DATA, order(m, w, l), msk);
            if (c[4])
                `CHK(mosi_oe, 1'b0)
            else
                `CHK(peer_rx & msk, order(d, w, l))
            // receive-only keeps clocking; full duplex stops when empty
            rdx(`SSC_ADR_STAT, {12'h000, c[4], 3'h0}, 16'h0008);
        end
        for (int j = 0; j < 3; j++)
        begin
            wr(`SSC_ADR_CTRL, 32'h00000000);
            wr(`SSC_ADR_STAT, 32'h00000004);
            nss_pull <= fpin[j];
            wr(`SSC_ADR_CTRL, fv[j]);
            // settle time for the pin synchroniser
            repeat (8) @(posedge ref_clk);
            rdx(`SSC_ADR_STAT, fe[j], 16'h0014);
        end
        conclude();
    end
endmodule
